// ---- shared/mmo_pkg.sv ----
// Constants and types shared by the manual output override block
package mmo_pkg;

  localparam int DAC_W  = 12;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int RATE_W = 16;
  localparam int TCNT_W = 32;

  localparam logic [DAC_W-1:0] DAC_MIN = 12'h000;
  localparam logic [DAC_W-1:0] DAC_MAX = 12'hFFF;
  localparam logic [DAC_W-1:0] DAC_ONE = 12'h001;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_CTRL  = 3'h0;
  localparam logic [ADDR_W-1:0] REG_SLOPE = 3'h1;
  localparam logic [ADDR_W-1:0] REG_RAMP  = 3'h2;
  localparam logic [ADDR_W-1:0] REG_OUT   = 3'h3;
  localparam logic [ADDR_W-1:0] REG_RAW   = 3'h4;
  localparam logic [ADDR_W-1:0] REG_STAT  = 3'h5;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DIS_BIT  = 2;
  localparam int CTRL_PROG_BIT = 3;
  localparam int CTRL_RAMP_BIT = 4;

  // Status register fields
  localparam int STAT_MERR_BIT  = 0;
  localparam int STAT_LERR_BIT  = 1;
  localparam int STAT_UPL_BIT   = 2;
  localparam int STAT_DNL_BIT   = 3;
  localparam int STAT_RAISE_BIT = 4;
  localparam int STAT_LOWER_BIT = 5;
  localparam int STAT_BUSY_BIT  = 6;

  typedef enum logic [1:0] {
    MM_UPDOWN,
    MM_CTRLIN,
    MM_LIM_NO,
    MM_LIM_NC
  } mmo_mode_t;

  localparam mmo_mode_t MODE_RST = MM_UPDOWN;
  localparam logic      DIS_RST  = 1'b0;
  localparam logic [RATE_W-1:0] RAMP_RST = 16'h1000;

  // Timebase and fixed slew
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICKS_PER_S    = 1000;
  localparam int TICK_PERIOD_NS = 1_000_000_000 / TICKS_PER_S;
  localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FIXED_SLEW_S   = 5;
  localparam longint FIXED_RATE_L =
    (longint'(DAC_MAX) * (longint'(1) << RATE_W))
    / (FIXED_SLEW_S * TICKS_PER_S);
  localparam logic [RATE_W-1:0] FIXED_RATE = RATE_W'(FIXED_RATE_L);

endpackage : mmo_pkg

// ---- rtl/mmo_manual_override.sv ----
// Manual-mode override of the DAC output code, with register port
`timescale 1ns/1ns
`default_nettype none

// Fractional rate accumulator: at most one step per tick
module mmo_rate_acc (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  input  wire logic              run,
  input  wire logic              tick,
  input  wire logic [15:0]       rate,
  output logic                   stepPulse
);
  logic [16:0] sum;
  logic [15:0] acc_reg;

  assign sum       = {1'b0, acc_reg} + {1'b0, rate};
  assign stepPulse = run && tick && sum[16];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_reg <= 16'h0000;
    end else if (clkEn) begin
      if (!run) begin
        acc_reg <= 16'h0000;
      end else if (tick) begin
        acc_reg <= sum[15:0];
      end
    end
  end
endmodule : mmo_rate_acc

// How it works
// R1: Up/down mode: both low hold, raise low up, lower low down, both high idle.
// R2: Both inputs are active low; open pin reads one, grounded reads zero.
// R3: Each slew step moves the DAC code by one on a 1 ms tick.
// R4: Slewing continues only while the commanding input stays active.
// R5: Fixed variant: full-range change takes 5 seconds.
// R6: Programmable variant: slew rate comes from the host-loaded slope value.
// R7: Up/down mode with either input low rejects host output writes, manual error.
// R8: Up/down mode with both low freezes the output and rejects host changes.
// R9: Controller mode: both low up, lower low only down, lower high idle.
// R10: Controller mode: lower enables, raise selects direction, output integrates.
// R11: Controller mode slews at the configured manual slew rate.
// R12: Two limit modes, normally open and normally closed, differ in decode.
// R13: Only down limit active rejects lowering output commands, raising ones proceed.
// R14: Only up limit active rejects raising commands, lowering ones proceed.
// R15: Both limits active reject every output command with a limit error.
// R16: No limit active lets output commands proceed as in other modes.
// R17: Limit decode on lower,raise per normally-open or normally-closed table.
// R18: Ramp variant: a limit in the ramp direction stops the ramp.
// R19: Raw limit inputs stay readable in status while manual modes run.
// R20: Up/down manual mode is selected after reset.
// R21: Two-bit mode field: up/down, controller, limits open, limits closed.
// R22: Disable bit set ignores both inputs for output control.
// R23: Slewing saturates at full scale; inputs are synchronised before decode.
module mmo_manual_override #(
  parameter int TICK_CYCLES = mmo_pkg::TICK_CYC
) (
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  input  wire logic                             clkEn,
  input  wire logic                             raiseN,
  input  wire logic                             lowerN,
  input  wire logic [mmo_pkg::ADDR_W-1:0]       regAddr,
  input  wire logic [mmo_pkg::DATA_W-1:0]       regWrData,
  input  wire logic                             regWrEn,
  input  wire logic                             regRdEn,
  output logic      [mmo_pkg::DATA_W-1:0]       regRdData,
  output logic      [mmo_pkg::DAC_W-1:0]        dacCode,
  output logic                                  manualErrPulse,
  output logic                                  limitErrPulse
);
  import mmo_pkg::*;

  localparam logic [TCNT_W-1:0] TICK_LAST = TCNT_W'(TICK_CYCLES - 1);

  logic [1:0]        raiseSync_reg, lowerSync_reg;
  logic              raiseQ, lowerQ;
  logic [TCNT_W-1:0] tickCnt_reg;
  logic              tick;
  mmo_mode_t         mode_reg;
  logic              disable_reg, progSlope_reg, rampEn_reg;
  logic [RATE_W-1:0] slope_reg, rampRate_reg, manRate;
  logic [DAC_W-1:0]  dac_reg, target_reg, newCode;
  logic              busy_reg;
  logic              mErr_reg, lErr_reg;
  logic [DATA_W-1:0] rdData_reg;
  logic              active, manUp, manDown, manRun, manualLock;
  logic              limitMode, upLim, dnLim, limRej;
  logic              wrOut, wrRaw, outOk, rawOk, newHigher, newLower;
  logic              manStep, rampStep, rampUp, rampStop;
  logic              mErrSet, lErrSet, errClr;

  // Pins are pulled up, so a one means released
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      raiseSync_reg <= 2'h3;
      lowerSync_reg <= 2'h3;
    end else if (clkEn) begin
      raiseSync_reg <= {raiseSync_reg[0], raiseN}; // [R23]
      lowerSync_reg <= {lowerSync_reg[0], lowerN}; // [R23]
    end
  end
  assign raiseQ = raiseSync_reg[1];
  assign lowerQ = lowerSync_reg[1];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tickCnt_reg <= '0;
    end else if (clkEn) begin
      tickCnt_reg <= tick ? '0 : tickCnt_reg + 1'b1; // [R3]
    end
  end
  assign tick = (tickCnt_reg == TICK_LAST);

  // Input decode
  assign active = !disable_reg; // [R22]
  always_comb begin
    manUp      = 1'b0;
    manDown    = 1'b0;
    manualLock = 1'b0;
    upLim      = 1'b0;
    dnLim      = 1'b0;
    unique case (mode_reg) // [R21]
      MM_UPDOWN: begin
        manUp      = !raiseQ && lowerQ; // [R1] [R2]
        manDown    = raiseQ && !lowerQ; // [R1]
        manualLock = !raiseQ || !lowerQ; // [R7] [R8]
      end
      MM_CTRLIN: begin
        manUp      = !lowerQ && !raiseQ; // [R9] [R10]
        manDown    = !lowerQ && raiseQ; // [R9] [R10]
        manualLock = !lowerQ;
      end
      MM_LIM_NO: begin
        upLim = !raiseQ; // [R17]
        dnLim = !lowerQ; // [R17]
      end
      MM_LIM_NC: begin
        upLim = raiseQ; // [R17] [R12]
        dnLim = lowerQ; // [R17] [R12]
      end
    endcase
    if (!active) begin
      manUp      = 1'b0;
      manDown    = 1'b0;
      manualLock = 1'b0;
      upLim      = 1'b0;
      dnLim      = 1'b0;
    end
  end
  assign limitMode = active && mode_reg[1];

  // Host commands
  assign wrOut     = regWrEn && (regAddr == REG_OUT);
  assign wrRaw     = regWrEn && (regAddr == REG_RAW);
  assign newCode   = regWrData[DAC_W-1:0];
  assign newHigher = newCode > dac_reg;
  assign newLower  = newCode < dac_reg;
  assign limRej    = limitMode && ((dnLim && upLim) // [R15]
                     || (dnLim && newLower) // [R13]
                     || (upLim && newHigher)); // [R14]
  assign outOk     = wrOut && !manualLock && !limRej; // [R16]
  assign rawOk     = wrRaw && !manualLock; // [R7]
  assign mErrSet   = (wrOut || wrRaw) && manualLock; // [R7] [R8]
  assign lErrSet   = wrOut && !manualLock && limRej;
  assign errClr    = regWrEn && (regAddr == REG_STAT);

  // Slew generation
  assign manRate = progSlope_reg ? slope_reg : FIXED_RATE; // [R5] [R6] [R11]
  assign manRun  = manUp || manDown; // [R4]
  assign rampUp  = target_reg > dac_reg;
  assign rampStop = busy_reg && (rampUp ? upLim : dnLim); // [R18]

  mmo_rate_acc u_manAcc (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .run       (manRun),
    .tick      (tick),
    .rate      (manRate),
    .stepPulse (manStep)
  );

  mmo_rate_acc u_rampAcc (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .run       (busy_reg && !manualLock),
    .tick      (tick),
    .rate      (rampRate_reg),
    .stepPulse (rampStep)
  );

  // Output code; host writes win, a manual lock stops any ramp
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dac_reg <= DAC_MIN;
    end else if (clkEn) begin
      if (rawOk || (outOk && !rampEn_reg)) begin
        dac_reg <= newCode;
      end else if (manStep) begin
        if (manUp && dac_reg != DAC_MAX) begin // [R23]
          dac_reg <= dac_reg + DAC_ONE; // [R3]
        end else if (manDown && dac_reg != DAC_MIN) begin // [R23]
          dac_reg <= dac_reg - DAC_ONE; // [R3]
        end
      end else if (rampStep && !rampStop && !manRun) begin
        dac_reg <= rampUp ? dac_reg + DAC_ONE : dac_reg - DAC_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_reg   <= 1'b0;
      target_reg <= DAC_MIN;
    end else if (clkEn) begin
      if (outOk && rampEn_reg) begin
        target_reg <= newCode;
        busy_reg   <= newCode != dac_reg;
      end else if (rawOk || rampStop || manualLock || manRun) begin
        busy_reg <= 1'b0; // [R18]
      end else if (busy_reg && target_reg == dac_reg) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg      <= MODE_RST; // [R20]
      disable_reg   <= DIS_RST;
      progSlope_reg <= 1'b0;
      rampEn_reg    <= 1'b0;
      slope_reg     <= FIXED_RATE;
      rampRate_reg  <= RAMP_RST;
    end else if (clkEn && regWrEn) begin
      if (regAddr == REG_CTRL) begin
        mode_reg      <= mmo_mode_t'(regWrData[CTRL_MODE_LSB +: 2]);
        disable_reg   <= regWrData[CTRL_DIS_BIT]; // [R22]
        progSlope_reg <= regWrData[CTRL_PROG_BIT];
        rampEn_reg    <= regWrData[CTRL_RAMP_BIT];
      end
      if (regAddr == REG_SLOPE) begin
        slope_reg <= regWrData; // [R6]
      end
      if (regAddr == REG_RAMP) begin
        rampRate_reg <= regWrData;
      end
    end
  end

  // Sticky errors: a new error beats a write-one clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mErr_reg       <= 1'b0;
      lErr_reg       <= 1'b0;
      manualErrPulse <= 1'b0;
      limitErrPulse  <= 1'b0;
    end else if (clkEn) begin
      mErr_reg <= mErrSet ||
                  (mErr_reg && !(errClr && regWrData[STAT_MERR_BIT]));
      lErr_reg <= lErrSet ||
                  (lErr_reg && !(errClr && regWrData[STAT_LERR_BIT]));
      manualErrPulse <= mErrSet;
      limitErrPulse  <= lErrSet;
    end
  end

  // Read port: data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData_reg <= '0;
    end else if (clkEn) begin
      rdData_reg <= '0;
      if (regRdEn) begin
        unique case (regAddr)
          REG_CTRL: begin
            rdData_reg[CTRL_MODE_LSB +: 2] <= mode_reg;
            rdData_reg[CTRL_DIS_BIT]       <= disable_reg;
            rdData_reg[CTRL_PROG_BIT]      <= progSlope_reg;
            rdData_reg[CTRL_RAMP_BIT]      <= rampEn_reg;
          end
          REG_SLOPE: rdData_reg <= slope_reg;
          REG_RAMP:  rdData_reg <= rampRate_reg;
          REG_OUT:   rdData_reg[DAC_W-1:0] <= dac_reg;
          REG_STAT: begin
            rdData_reg[STAT_MERR_BIT]  <= mErr_reg;
            rdData_reg[STAT_LERR_BIT]  <= lErr_reg;
            rdData_reg[STAT_UPL_BIT]   <= upLim;
            rdData_reg[STAT_DNL_BIT]   <= dnLim;
            rdData_reg[STAT_RAISE_BIT] <= raiseQ; // [R19]
            rdData_reg[STAT_LOWER_BIT] <= lowerQ; // [R19]
            rdData_reg[STAT_BUSY_BIT]  <= busy_reg;
          end
          default: rdData_reg <= '0;
        endcase
      end
    end
  end

  assign regRdData = rdData_reg;
  assign dacCode   = dac_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_hold_freeze: assert property ( // [R8]
    clkEn && active && mode_reg == MM_UPDOWN && !raiseQ && !lowerQ
    |=> dac_reg == $past(dac_reg))
    else $error("output moved while both inputs hold");
  chk_manual_reject: assert property ( // [R7]
    clkEn && (wrOut || wrRaw) && manualLock
    |=> manualErrPulse && mErr_reg)
    else $error("host write under manual lock not flagged");
  chk_limit_down: assert property ( // [R13]
    clkEn && wrOut && limitMode && dnLim && newLower
    |=> limitErrPulse && lErr_reg)
    else $error("lowering write under down limit accepted");
  chk_limit_up: assert property ( // [R14]
    clkEn && wrOut && limitMode && upLim && !dnLim && newLower
    && !rampEn_reg |=> !limitErrPulse && dac_reg == $past(newCode))
    else $error("lowering write under up limit refused");
  chk_limit_free: assert property ( // [R16]
    clkEn && wrOut && limitMode && !upLim && !dnLim && !rampEn_reg
    |=> dac_reg == $past(newCode))
    else $error("write with no limit not applied");
  chk_slew_step: assert property ( // [R3]
    clkEn && !wrOut && !wrRaw
    |=> (dac_reg - $past(dac_reg) == DAC_ONE)
     || ($past(dac_reg) - dac_reg == DAC_ONE)
     || (dac_reg == $past(dac_reg)))
    else $error("slew moved more than one code");
  chk_no_wrap: assert property ( // [R23]
    clkEn && manUp && dac_reg == DAC_MAX && !wrOut && !wrRaw
    |=> dac_reg == DAC_MAX)
    else $error("manual slew wrapped at full scale");
  chk_disable_idle: assert property ( // [R22]
    clkEn && disable_reg && !busy_reg && !wrOut && !wrRaw
    |=> dac_reg == $past(dac_reg))
    else $error("output moved with manual modes disabled");
  chk_ramp_limit: assert property ( // [R18]
    clkEn && busy_reg && rampUp && upLim && !(wrOut && outOk)
    |=> !busy_reg)
    else $error("ramp kept running into a limit");
  chk_ramp_down: assert property ( // [R18]
    clkEn && busy_reg && !rampUp && dnLim && !outOk
    |=> !busy_reg)
    else $error("falling ramp kept running into a limit");
  chk_limit_both: assert property ( // [R15]
    clkEn && wrOut && limitMode && upLim && dnLim
    |=> limitErrPulse && dac_reg == $past(dac_reg))
    else $error("write accepted with both limits active");
  chk_ctrl_idle: assert property ( // [R9]
    clkEn && active && mode_reg == MM_CTRLIN && lowerQ && !busy_reg
    && !wrOut && !wrRaw |=> dac_reg == $past(dac_reg))
    else $error("output moved with controller input off");
  chk_read_idle: assert property (
    clkEn && !regRdEn |=> regRdData == '0)
    else $error("read data stood beyond its cycle");

  cov_manual_up: cover property (clkEn && manStep && manUp);
  cov_ctrl_down: cover property (
    clkEn && mode_reg == MM_CTRLIN && manStep && manDown);
  cov_limit_err: cover property (clkEn && lErrSet);
  cov_ramp_stop: cover property (clkEn && rampStop);

endmodule : mmo_manual_override

`default_nettype wire

// ---- tb/mmo_switch_model.sv ----
// Operator switch pair that drives the two active-low manual inputs
`timescale 1ns/1ns
`default_nettype none
module mmo_switch_model (
  input  wire logic pressRaise,
  input  wire logic pressLower,
  output logic      raiseN,
  output logic      lowerN
);
  // Open contact floats to the pull-up level, a closed one grounds the pin
  assign raiseN = pressRaise ? 1'b0 : 1'b1;
  assign lowerN = pressLower ? 1'b0 : 1'b1;
endmodule : mmo_switch_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the manual output override block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mmo_pkg::*;
  // Short tick keeps slews to a few hundred cycles
  localparam int TC = 4;
  logic               sys_clk, rst, raiseN, lowerN, regWrEn, regRdEn;
  logic               pressRaise, pressLower, mPulse, lPulse, mErr, lErr;
  logic               lk, er, clkEn;
  logic [1:0]         dir, lim;
  logic [ADDR_W-1:0]  regAddr;
  logic [DATA_W-1:0]  regWrData, regRdData, rdVal;
  logic [DAC_W-1:0]   dacCode, base, tgt, v1, dlt;
  int                 num_errors, tests_run, cycles, seed;

  mmo_switch_model SW (.pressRaise(pressRaise), .pressLower(pressLower),
    .raiseN(raiseN), .lowerN(lowerN));
  mmo_manual_override #(.TICK_CYCLES(TC)) DUT (.sys_clk(sys_clk),
    .rst(rst), .clkEn(clkEn), .raiseN(raiseN), .lowerN(lowerN),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .dacCode(dacCode),
    .manualErrPulse(mPulse), .limitErrPulse(lPulse));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] sn);
    tests_run++;
    if (sn !== ex) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    #1;
    mErr = mPulse;
    lErr = lPulse;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    rdVal = regRdData;
  endtask : rd

  // Inputs pass a two-flop synchroniser before they count
  task automatic sw(input logic r, input logic l);
    @(posedge sys_clk);
    pressRaise <= r;
    pressLower <= l;
    repeat (3) @(posedge sys_clk);
  endtask : sw

  // Direction code: 1 up, 2 down, 0 none; r and l are pin levels
  function automatic logic [1:0] expDir(input logic m, input logic r,
                                        input logic l);
    if (!m) return (!r && l) ? 2'h1 : (r && !l) ? 2'h2 : 2'h0;
    return l ? 2'h0 : (r ? 2'h2 : 2'h1);
  endfunction : expDir

  // Returns {up limit, down limit}
  function automatic logic [1:0] limFn(input logic nc, input logic r,
                                       input logic l);
    return {nc ? r : !r, nc ? l : !l};
  endfunction : limFn

  initial begin
    seed = 72;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    rst = 1'b1;
    clkEn = 1'b1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = '0;
    regWrData = '0;
    pressRaise = 1'b0;
    pressLower = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(REG_CTRL);
    chk("ctrl", 16'h0000, rdVal);
    chk("dac", 16'h0000, {4'h0, dacCode});
    rd(REG_SLOPE);
    chk("slope", FIXED_RATE, rdVal);
    rd(3'h7);
    chk("unmapped", 16'h0000, rdVal);
    // About 100 ticks at the fixed rate gives roughly 82 codes
    sw(1'b1, 1'b0);
    repeat (400) @(posedge sys_clk);
    sw(1'b0, 1'b0);
    chk("fixed", 16'h0001,
        {15'h0, dacCode >= 12'h04E && dacCode <= 12'h054});
    wr(REG_SLOPE, 16'hFFFF);
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        wr(REG_CTRL, 16'h0008 | 16'(m));
        base = 12'h800;
        wr(REG_OUT, {4'h0, base});
        sw(!c[1], !c[0]);
        tgt = 12'($unsigned($random(seed)));
        lk = m ? !c[0] : (!c[1] || !c[0]);
        wr(REG_OUT, {4'h0, tgt});
        chk("lock", {15'h0, lk}, {15'h0, mErr});
        if (!lk) base = tgt;
        repeat (36) @(posedge sys_clk);
        sw(1'b0, 1'b0);
        dir = (dacCode == base) ? 2'h0 : (dacCode > base) ? 2'h1 : 2'h2;
        dlt = (dacCode > base) ? dacCode - base : base - dacCode;
        chk("dir", {14'h0, expDir(m[0], c[1], c[0])},
            {14'h0, dir});
        if (dir != 2'h0) chk("rate", 16'h0001,
                             {15'h0, dlt >= 7 && dlt <= 11});
      end
    end
    wr(REG_CTRL, 16'h0008);
    wr(REG_OUT, 16'h0FFD);
    sw(1'b1, 1'b0);
    wr(REG_RAW, 16'h0000);
    chk("raw lock", 16'h0001, {15'h0, mErr});
    repeat (40) @(posedge sys_clk);
    sw(1'b0, 1'b0);
    chk("top", 16'h0FFF, {4'h0, dacCode});
    wr(REG_OUT, 16'h0002);
    sw(1'b0, 1'b1);
    repeat (40) @(posedge sys_clk);
    sw(1'b0, 1'b0);
    chk("bottom", 16'h0000, {4'h0, dacCode});
    // A low enable must hold a running slew where it is
    sw(1'b1, 1'b0);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    #1 v1 = dacCode;
    repeat (40) @(posedge sys_clk);
    chk("freeze", {4'h0, v1}, {4'h0, dacCode});
    clkEn <= 1'b1;
    sw(1'b0, 1'b0);
    wr(REG_CTRL, 16'h000C);
    sw(1'b1, 1'b0);
    wr(REG_OUT, 16'h0123);
    chk("dis err", 16'h0000, {15'h0, mErr});
    repeat (40) @(posedge sys_clk);
    chk("dis dac", 16'h0123, {4'h0, dacCode});
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        sw(1'b0, 1'b0);
        wr(REG_CTRL, 16'h0008);
        wr(REG_OUT, 16'h0800);
        wr(REG_CTRL, 16'h000A | 16'(m));
        sw(!c[1], !c[0]);
        tgt = 12'($unsigned($random(seed)));
        lim = limFn(m[0], c[1], c[0]);
        er = (lim[1] && lim[0]) || (lim[0] && tgt < 12'h800)
          || (lim[1] && tgt > 12'h800);
        wr(REG_OUT, {4'h0, tgt});
        chk("limit", {15'h0, er}, {15'h0, lErr});
        chk("lim dac", {4'h0, er ? 12'h800 : tgt}, {4'h0, dacCode});
        rd(REG_STAT);
        chk("stat", {12'h0, c[0], c[1], lim[0], lim[1]},
            {12'h0, rdVal[5:2]});
      end
    end
    // Ramp toward 0x200, then close the up limit part way
    sw(1'b0, 1'b0);
    wr(REG_CTRL, 16'h0008);
    wr(REG_OUT, 16'h0100);
    wr(REG_RAMP, 16'hFFFF);
    wr(REG_CTRL, 16'h001A);
    wr(REG_OUT, 16'h0200);
    repeat (40) @(posedge sys_clk);
    sw(1'b1, 1'b0);
    repeat (2) @(posedge sys_clk);
    v1 = dacCode;
    repeat (40) @(posedge sys_clk);
    chk("ramp stop", {4'h0, v1}, {4'h0, dacCode});
    chk("ramp mid", 16'h0001, {15'h0, v1 > 12'h100 && v1 < 12'h200});
    rd(REG_STAT);
    chk("busy", 16'h0000, {15'h0, rdVal[STAT_BUSY_BIT]});
    summarize();
  end
endmodule : tb_top
`default_nettype wire
